// ===== verilog/adcmo_pkg.sv
// Shared constants, encodings and carrier types of the converter output control block.
package adcmo_pkg;
  // Width of the parallel sample word.
  localparam int ADCMO_DATA_W = 11;
  // Index of the most significant data bit.
  localparam int ADCMO_MSB = ADCMO_DATA_W - 1;
  // System clock rate in MHz.
  localparam int ADCMO_SYS_MHZ = 10;
  // Encode cycles the stabilizer needs to relock after a long stop.
  localparam logic [7:0] ADCMO_DCS_LOCK_CYCLES = 8'h64;
  // Encode cycles of recovery after nap.
  localparam logic [7:0] ADCMO_NAP_RECOVER_CYCLES = 8'h64;
  // Time without an encode edge that counts as a stopped clock, in microseconds.
  localparam int ADCMO_STOP_US = 10;
  // System cycles without an encode edge that count as a stopped clock.
  localparam logic [7:0] ADCMO_STOP_CYCLES = 8'(ADCMO_STOP_US * ADCMO_SYS_MHZ);
  // Recovery time after sleep, in milliseconds.
  localparam int ADCMO_SLEEP_RECOVER_MS = 1;
  // Saturation value of the encode period counter.
  localparam logic [7:0] ADCMO_PERIOD_MAX = 8'hFF;
  // Two-bit codes of the four mode input levels.
  localparam logic [1:0] ADCMO_MODE_GND = 2'h0;
  localparam logic [1:0] ADCMO_MODE_THIRD = 2'h1;
  localparam logic [1:0] ADCMO_MODE_TWO_THIRDS = 2'h2;
  localparam logic [1:0] ADCMO_MODE_SUPPLY = 2'h3;
  // Depth of the sample buffer.
  localparam int ADCMO_BUF_DEPTH = 2;

  // Power states, Gray coded along run, nap, sleep and wake.
  typedef enum logic [1:0] {
    ADCMO_RUN = 2'h0,
    ADCMO_NAP = 2'h1,
    ADCMO_SLEEP = 2'h3,
    ADCMO_WAKE = 2'h2
  } adcmo_power_t;

  // One converted sample with its over-range flag.
  typedef struct packed {
    logic over_range;
    logic [ADCMO_DATA_W-1:0] code;
  } adcmo_word_t;
endpackage

// ===== verilog/adcmo_core.sv
// Output, mode and power control of the pipelined sampling converter.
//
// Summary of operation
// - Stabilizer samples encode rise, makes own fall.
// - Stabilizer accepts 20-80 percent, keeps 50 percent.
// - After long stop, relock takes 100 cycles.
// - Mode level picks offset binary or two's complement.
// - Middle mode levels enable the stabilizer.
// - Over-range flag high when input out of range.
// - Data-ready clock is delayed encode clock.
// - Data changes on the same edge the data-ready clock rises.
// - Output enable high floats data, flag, clock.
// - Power-down low means normal operation.
// - Power-down and enable high gives sleep.
// - After sleep, samples invalid for milliseconds.
// - Power-down high, enable low gives nap.
// - Sleep and nap float every digital output.
`timescale 1ns/1ps
module adcmo_core
  import adcmo_pkg::*;
#(
  // Sleep recovery in system cycles; shorten in simulation.
  parameter int SLEEP_RECOVER_CYCLES = ADCMO_SLEEP_RECOVER_MS * 1000 * ADCMO_SYS_MHZ
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Encode clock pins.
  input wire logic encode_clock_pos,
  input wire logic encode_clock_neg,
  // Static control pins.
  input wire logic [1:0] mode_level,
  input wire logic power_down_select,
  input wire logic output_enable_n,
  // Quantizer result, same clock domain.
  input wire adcmo_word_t conv_word,
  input wire logic conv_valid,
  output logic conv_ready,
  // Receiver back-pressure pin.
  input wire logic out_ready,
  // Parallel output pins with their enables.
  output logic [ADCMO_DATA_W-1:0] sample_data,
  output logic sample_data_oe,
  output logic over_range_flag,
  output logic over_range_oe,
  output logic data_ready_clock,
  output logic data_ready_oe,
  // Status.
  output logic dcs_locked,
  output adcmo_power_t power_state
);

  // Synchroniser stages for every pin input; first stages feed only second stages.
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  always_ff @(posedge sys_clk) begin
    pin_s1_q <= {encode_clock_pos, encode_clock_neg, mode_level, power_down_select, output_enable_n, out_ready};
    pin_s2_q <= pin_s1_q;
  end

  // Named views of the synchronised pins.
  wire pos_s = pin_s2_q[6];
  wire neg_s = pin_s2_q[5];
  wire [1:0] mode_s = pin_s2_q[4:3];
  wire pd_s = pin_s2_q[2];
  wire oe_n_s = pin_s2_q[1];
  wire rdy_s = pin_s2_q[0];

  // Decoded mode: format from the upper half, stabilizer from the middle levels.
  wire fmt_twos = (mode_s == ADCMO_MODE_TWO_THIRDS) || (mode_s == ADCMO_MODE_SUPPLY);
  wire dcs_sel = (mode_s == ADCMO_MODE_THIRD) || (mode_s == ADCMO_MODE_TWO_THIRDS);

  // Registered mode decode.
  logic dcs_en_q;
  logic fmt_twos_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dcs_en_q <= 1'b0;
      fmt_twos_q <= 1'b0;
    end else begin
      dcs_en_q <= dcs_sel;
      fmt_twos_q <= fmt_twos;
    end
  end

  // Encode level: differential when the stabilizer is off, positive pin alone when on.
  wire enc_diff = pos_s & ~neg_s;
  logic enc_diff_q;
  logic pos_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      enc_diff_q <= 1'b0;
      pos_q <= 1'b0;
    end else begin
      enc_diff_q <= enc_diff;
      pos_q <= pos_s;
    end
  end
  wire pos_rise = pos_s & ~pos_q;
  wire diff_rise = enc_diff & ~enc_diff_q;
  // With the stabilizer only the rising edge of the positive pin counts; its fall is ignored.
  wire enc_rise = dcs_en_q ? pos_rise : diff_rise;

  // Period measurement between rises and stop detection.
  logic [7:0] per_cnt_q;
  logic [7:0] half_q;
  logic [7:0] lock_cnt_q;
  logic locked_q;
  wire per_sat = (per_cnt_q == ADCMO_PERIOD_MAX);
  wire clk_stopped = (per_cnt_q >= ADCMO_STOP_CYCLES);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      per_cnt_q <= 8'h00;
      half_q <= 8'h00;
    end else if (enc_rise) begin
      per_cnt_q <= 8'h00;
      half_q <= {1'b0, per_cnt_q[7:1]};
    end else if (!per_sat) begin
      per_cnt_q <= per_cnt_q + 8'h01;
    end
  end

  // Lock counter: a stopped clock drops lock; relock needs the full count of rises.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lock_cnt_q <= 8'h00;
      locked_q <= 1'b0;
    end else if (clk_stopped) begin
      lock_cnt_q <= 8'h00;
      locked_q <= 1'b0;
    end else if (enc_rise && !locked_q) begin
      lock_cnt_q <= lock_cnt_q + 8'h01;
      locked_q <= (lock_cnt_q + 8'h01 >= ADCMO_DCS_LOCK_CYCLES);
    end
  end
  // Sampling is valid without the stabilizer, or once it has locked.
  wire timing_ok = !dcs_en_q || locked_q;

  // Internal clock: stabilized form is high for half the measured period.
  logic int_clk_q;
  wire half_done = (per_cnt_q >= half_q);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_clk_q <= 1'b0;
    end else if (enc_rise) begin
      int_clk_q <= 1'b1;
    end else if (dcs_en_q) begin
      int_clk_q <= int_clk_q & ~half_done;
    end else begin
      int_clk_q <= enc_diff;
    end
  end

  // Power mode decode.
  wire want_sleep = pd_s & oe_n_s;
  wire want_nap = pd_s & ~oe_n_s;
  adcmo_power_t pstate_q;
  adcmo_power_t pstate_d;
  logic [31:0] wake_cnt_q;
  logic from_sleep_q;
  wire [31:0] wake_goal = from_sleep_q ? 32'(SLEEP_RECOVER_CYCLES) : 32'(ADCMO_NAP_RECOVER_CYCLES);
  wire wake_done = (wake_cnt_q >= wake_goal);

  // Power state selection.
  always_comb begin
    pstate_d = pstate_q;
    case (pstate_q)
      ADCMO_RUN: begin
        if (want_sleep) begin
          pstate_d = ADCMO_SLEEP;
        end else if (want_nap) begin
          pstate_d = ADCMO_NAP;
        end
      end
      ADCMO_NAP, ADCMO_SLEEP: begin
        if (!pd_s) begin
          pstate_d = ADCMO_WAKE;
        end else if (want_sleep) begin
          pstate_d = ADCMO_SLEEP;
        end else begin
          pstate_d = ADCMO_NAP;
        end
      end
      ADCMO_WAKE: begin
        if (pd_s) begin
          pstate_d = want_sleep ? ADCMO_SLEEP : ADCMO_NAP;
        end else if (wake_done) begin
          pstate_d = ADCMO_RUN;
        end
      end
      default: begin
        pstate_d = ADCMO_RUN;
      end
    endcase
  end

  // Power state register and recovery counting.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pstate_q <= ADCMO_RUN;
      from_sleep_q <= 1'b0;
      wake_cnt_q <= 32'h0000_0000;
    end else begin
      pstate_q <= pstate_d;
      if (pstate_q == ADCMO_SLEEP) begin
        from_sleep_q <= 1'b1;
      end else if (pstate_q == ADCMO_NAP) begin
        from_sleep_q <= 1'b0;
      end
      if (pstate_q != ADCMO_WAKE) begin
        wake_cnt_q <= 32'h0000_0000;
      end else if (from_sleep_q || enc_rise) begin
        // Sleep recovery counts system cycles; nap recovery counts encode cycles.
        wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Sample push: only on a sampling edge, in run, with valid timing.
  wire running = (pstate_q == ADCMO_RUN);
  logic [1:0] count_q;
  wire buf_in_ready = (count_q != 2'(ADCMO_BUF_DEPTH));
  wire push = enc_rise && running && timing_ok && conv_valid && buf_in_ready;
  // Formatted word: two's complement is offset binary with the MSB inverted.
  adcmo_word_t push_word;
  assign push_word.over_range = conv_word.over_range;
  assign push_word.code = {conv_word.code[ADCMO_MSB] ^ fmt_twos_q, conv_word.code[ADCMO_MSB-1:0]};

  // Data-ready clock: internal clock delayed one cycle; its rise pops the buffer.
  logic drc_q;
  wire drc_rise = int_clk_q & ~drc_q;
  wire pop = drc_rise && running && rdy_s && (count_q != 2'h0);

  // Two-entry buffer storage and indices.
  adcmo_word_t slot_q [ADCMO_BUF_DEPTH];
  logic wr_idx_q;
  logic rd_idx_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_idx_q <= 1'b0;
      rd_idx_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        slot_q[wr_idx_q] <= push_word;
        wr_idx_q <= ~wr_idx_q;
      end
      if (pop) begin
        rd_idx_q <= ~rd_idx_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Output drive: data changes on the same edge the data-ready clock rises.
  logic [ADCMO_DATA_W-1:0] data_q;
  logic of_q;
  logic oe_q;
  logic ready_q;
  wire drive_on = running && !oe_n_s;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drc_q <= 1'b0;
      data_q <= {ADCMO_DATA_W{1'b0}};
      of_q <= 1'b0;
      oe_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      drc_q <= int_clk_q;
      oe_q <= drive_on;
      ready_q <= (count_q == 2'h0) || ((count_q == 2'h1) && !push);
      if (pop) begin
        data_q <= slot_q[rd_idx_q].code;
        of_q <= slot_q[rd_idx_q].over_range;
      end
    end
  end

  // Port drive, all from flip-flops.
  assign sample_data = data_q;
  assign over_range_flag = of_q;
  assign data_ready_clock = drc_q;
  assign sample_data_oe = oe_q;
  assign over_range_oe = oe_q;
  assign data_ready_oe = oe_q;
  assign conv_ready = ready_q;
  assign dcs_locked = locked_q;
  assign power_state = pstate_q;

  // Checks on the block's own behaviour.
  // Format: lower bits pass unchanged, the MSB flips only for the two upper mode levels.
  fmt_msb_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (push && $past(rst_n)) |-> (push_word.code[ADCMO_MSB-1:0] == conv_word.code[ADCMO_MSB-1:0]) &&
      ((push_word.code[ADCMO_MSB] != conv_word.code[ADCMO_MSB]) == $past(mode_s[1])))
    else $error("sample format does not follow mode");
  // The stabilizer is on exactly for the two middle mode levels, one cycle after the synchronised level.
  dcs_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n |=> dcs_en_q == (($past(mode_s) == ADCMO_MODE_THIRD) || ($past(mode_s) == ADCMO_MODE_TWO_THIRDS)))
    else $error("stabilizer enable does not follow mode");
  fmt_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode_s == ADCMO_MODE_THIRD) [*2] |-> !fmt_twos_q)
    else $error("one-third level must give offset binary");
  oe_hiz_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    oe_n_s |=> !sample_data_oe && !over_range_oe && !data_ready_oe)
    else $error("outputs driven while enable high");
  power_hiz_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pstate_q == ADCMO_SLEEP || pstate_q == ADCMO_NAP) |=> !sample_data_oe)
    else $error("outputs driven in power mode");
  sleep_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (running && pd_s && oe_n_s) |=> pstate_q == ADCMO_SLEEP)
    else $error("sleep not entered");
  nap_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (running && pd_s && !oe_n_s) |=> pstate_q == ADCMO_NAP)
    else $error("nap not entered");
  run_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (running && !pd_s) |=> running)
    else $error("left run with power-down low");
  wake_discard_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pstate_q == ADCMO_WAKE) |-> !push)
    else $error("sample accepted during recovery");
  drc_update_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pop |=> $rose(data_ready_clock) && (sample_data == $past(slot_q[rd_idx_q].code)))
    else $error("data not updated with data-ready rise");
  relock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(locked_q) |-> !locked_q [*8])
    else $error("stabilizer relocked too soon");
  drc_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(int_clk_q) |=> data_ready_clock)
    else $error("data-ready clock not following encode");
  // The flag must leave the buffer together with the code it belongs to.
  of_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pop |=> over_range_flag == $past(slot_q[rd_idx_q].over_range))
    else $error("over-range flag not sent with its word");
  // With the stabilizer on, only a rise of the positive pin may start a sample.
  dcs_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dcs_en_q && !(pos_s && !pos_q)) |-> !enc_rise)
    else $error("stabilizer took an edge other than the positive rise");
endmodule

// ===== test/adcmo_rx_model.sv
// Receiver model that latches converter samples on the falling data-ready edge.
`timescale 1ns/1ps
module adcmo_rx_model
  import adcmo_pkg::*;
(
  // Pins from the converter.
  input wire logic data_ready_clock,
  input wire logic data_ready_oe,
  input wire logic [ADCMO_DATA_W-1:0] sample_data,
  input wire logic over_range_flag,
  // Stall command from the bench.
  input wire logic stall,
  // Back-pressure pin and latched words.
  output logic out_ready,
  output adcmo_word_t rx_word,
  output int rx_count
);
  // Ready is the inverse of the stall command.
  assign out_ready = !stall;
  initial begin
    rx_word = '0;
    rx_count = 0;
  end
  // A fresh word is latched only while the pins are driven, stale repeats are ignored.
  always @(negedge data_ready_clock) begin
    if (data_ready_oe === 1'b1 && {over_range_flag, sample_data} !== rx_word) begin
      rx_word <= {over_range_flag, sample_data};
      rx_count <= rx_count + 1;
    end
  end
endmodule

// ===== test/tb.sv
// Self-checking bench of the converter output control block.
`timescale 1ns/1ps
module tb;
  import adcmo_pkg::*;
  // Pins and bench state.
  logic sys_clk, rst_n, encode_clock_pos, enc_run, power_down_select, output_enable_n;
  logic conv_valid, conv_ready, out_ready, stall, sample_data_oe, over_range_flag, over_range_oe;
  logic data_ready_clock, data_ready_oe, dcs_locked;
  logic [1:0] mode_level;
  logic [ADCMO_DATA_W-1:0] sample_data;
  adcmo_power_t power_state;
  adcmo_word_t conv_word, rx_word, prev_e;
  adcmo_word_t exp_q[$];
  int rx_count, bad_count, check_count, seed, n, enc_hi;
  // Sleep recovery is shortened to 20 cycles.
  adcmo_core #(.SLEEP_RECOVER_CYCLES(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .encode_clock_pos(encode_clock_pos), .encode_clock_neg(!encode_clock_pos), .mode_level(mode_level),
    .power_down_select(power_down_select), .output_enable_n(output_enable_n), .conv_word(conv_word),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .out_ready(out_ready), .sample_data(sample_data),
    .sample_data_oe(sample_data_oe), .over_range_flag(over_range_flag), .over_range_oe(over_range_oe),
    .data_ready_clock(data_ready_clock), .data_ready_oe(data_ready_oe), .dcs_locked(dcs_locked),
    .power_state(power_state));
  adcmo_rx_model rx (.data_ready_clock(data_ready_clock), .data_ready_oe(data_ready_oe),
    .sample_data(sample_data), .over_range_flag(over_range_flag), .stall(stall), .out_ready(out_ready),
    .rx_word(rx_word), .rx_count(rx_count));
  // System clock of 100 ns.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end
  // Encode clock of 800 ns with a chosen high time, parked low while stopped.
  initial begin
    encode_clock_pos = 1'b0;
    #37;
    forever begin
      #(800 - enc_hi) encode_clock_pos = enc_run;
      #(enc_hi) encode_clock_pos = 1'b0;
    end
  end
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Compares a sample word.
  task automatic check_word(input string name, input adcmo_word_t exp, input adcmo_word_t got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Compares a flag or a state code.
  task automatic check_bit(input string name, input logic [1:0] exp, input logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Waits a bounded time for run state, lock or an empty note queue.
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (!((sel == 0 && power_state === ADCMO_RUN && sample_data_oe === 1'b1) ||
        (sel == 1 && dcs_locked === 1'b1) || (sel == 2 && exp_q.size() == 0))) begin
      @(negedge sys_clk);
      n++;
      if (n > lim) begin
        bad_count++;
        $display("wrong value wait %0d expected done seen timeout", sel);
        complete_run();
      end
    end
    @(posedge sys_clk);
  endtask
  // Offers one random word per encode period while the buffer has room, noting the expected form.
  task automatic send(input int k);
    adcmo_word_t w;
    for (int i = 0; i <= k; i++) begin
      @(posedge encode_clock_pos);
      repeat (4) @(posedge sys_clk);
      if (i < k && conv_ready === 1'b1) begin
        w = 12'($random(seed));
        w.code[ADCMO_MSB] = w.code[ADCMO_MSB] ^ mode_level[1];
        while (w == prev_e) w.code = w.code + 11'h1;
        exp_q.push_back(w);
        prev_e = w;
        w.code[ADCMO_MSB] = w.code[ADCMO_MSB] ^ mode_level[1];
        conv_word <= w;
        conv_valid <= 1'b1;
      end else begin
        conv_valid <= 1'b0;
      end
    end
  endtask
  // Each word latched by the receiver is matched against the oldest note.
  always @(rx_count) begin
    if (rst_n === 1'b1) begin
      if (exp_q.size() > 0) begin
        check_word("rx_word", exp_q.pop_front(), rx_word);
      end else begin
        bad_count++;
        $display("wrong value rx_word expected none seen %h", rx_word);
      end
    end
  end
  // Main sequence.
  initial begin
    seed = 69;
    enc_hi = 400;
    rst_n = 1'b0;
    enc_run = 1'b1;
    power_down_select = 1'b0;
    output_enable_n = 1'b0;
    mode_level = ADCMO_MODE_GND;
    conv_valid = 1'b0;
    conv_word = '0;
    stall = 1'b0;
    prev_e = '0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_for(0, 50);
    check_bit("power_state", ADCMO_RUN, power_state);
    // All four mode levels, the stabilized ones at skewed duty.
    for (int m = 0; m < 4; m++) begin
      // Duty returns to half before a mode change and is skewed only once the stabilizer is on.
      enc_hi = 400;
      mode_level <= m[1:0];
      repeat (10) @(posedge sys_clk);
      if (m == 1 || m == 2) begin
        enc_hi = (m == 1) ? 160 : 640;
        wait_for(1, 1200);
      end
      // Lock is kept once reached; only a stopped encode clock drops it.
      check_bit("dcs_locked", {1'b0, m != 0}, dcs_locked);
      send(6);
      wait_for(2, 100);
      if (m == 2) begin
        enc_run <= 1'b0;
        repeat (200) @(posedge sys_clk);
        check_bit("dcs_locked", 0, dcs_locked);
        enc_run <= 1'b1;
        repeat (90) @(posedge encode_clock_pos);
        check_bit("dcs_locked", 0, dcs_locked);
        wait_for(1, 300);
        send(4);
        wait_for(2, 100);
      end
    end
    // Receiver stall fills the buffer, then drains it.
    stall <= 1'b1;
    send(6);
    check_bit("conv_ready", 0, conv_ready);
    stall <= 1'b0;
    wait_for(2, 100);
    // Output enable is toggled only while idle.
    output_enable_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check_bit("out_oe", 0, sample_data_oe | over_range_oe | data_ready_oe);
    check_bit("power_state", ADCMO_RUN, power_state);
    power_down_select <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check_bit("power_state", ADCMO_SLEEP, power_state);
    check_bit("out_oe", 0, sample_data_oe | over_range_oe | data_ready_oe);
    power_down_select <= 1'b0;
    output_enable_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check_bit("power_state", ADCMO_WAKE, power_state);
    wait_for(0, 30);
    send(3);
    wait_for(2, 100);
    power_down_select <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check_bit("power_state", ADCMO_NAP, power_state);
    check_bit("out_oe", 0, sample_data_oe | over_range_oe | data_ready_oe);
    power_down_select <= 1'b0;
    repeat (80) @(posedge encode_clock_pos);
    check_bit("power_state", ADCMO_WAKE, power_state);
    wait_for(0, 300);
    send(3);
    wait_for(2, 100);
    complete_run();
  end
endmodule
